// ### design/msc_pkg.sv
package msc_pkg;
  // ----------------------------------------------------------------
  // speed source encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MSC_SRC_ANALOG = 2'h0,  // amplitude on the speed pin
    MSC_SRC_DUTY   = 2'h1,  // duty cycle on the speed pin
    MSC_SRC_HOST   = 2'h2,  // value written by the host
    MSC_SRC_FREQ   = 2'h3   // frequency on the speed pin
  } msc_src_t;

  // ----------------------------------------------------------------
  // widths and timing
  // ----------------------------------------------------------------
  localparam int MSC_CMD_W = 16;              // speed command width, full scale all ones
  localparam int MSC_CNT_W = 24;              // period counter width
  localparam int MSC_CLK_HZ = 200000000;      // core clock rate
  localparam int MSC_FULL_FREQ_HZ = 10000;    // full-scale speed pin frequency
  localparam int MSC_FULL_FREQ_CYC = MSC_CLK_HZ / MSC_FULL_FREQ_HZ;
  localparam logic [MSC_CMD_W-1:0] MSC_CMD_FULL = 16'hffff;
  localparam logic [MSC_CMD_W-1:0] MSC_CMD_ZERO = 16'h0000;
  localparam logic [MSC_CNT_W-1:0] MSC_CNT_ZERO = 24'h000000;
  localparam logic [MSC_CNT_W-1:0] MSC_CNT_MAX = 24'hffffff;
  // duty band divisors: period cycles for the low and high band, log2
  localparam int MSC_BAND_LO_SH = 16;         // periods up to 65536 cycles
  localparam int MSC_BAND_HI_SH = 12;         // periods up to 4096 cycles
endpackage : msc_pkg

// ### design/msc_meas_if.sv
// measured period hand-off between the pin timer and the core
interface msc_meas_if;
  logic [23:0] period;   // cycles between two rising edges
  logic [23:0] high;     // high cycles in that period
  logic strobe;          // one cycle when a new period is ready
  modport timer (output period, output high, output strobe);
  modport core (input period, input high, input strobe);
endinterface : msc_meas_if

// ### design/msc_pin_timer.sv
module msc_pin_timer
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic enable_i,
  input wire logic pin_i,          // already synchronised
  msc_meas_if.timer meas
);
  import msc_pkg::*;

  // ----------------------------------------------------------------
  // period and high-time counters
  // ----------------------------------------------------------------
  logic prev_q;                      // last pin level for edge detect
  logic [MSC_CNT_W-1:0] cnt_q;       // cycles since the last rise
  logic [MSC_CNT_W-1:0] hi_q;        // high cycles since the last rise
  logic [MSC_CNT_W-1:0] per_q;       // captured period
  logic [MSC_CNT_W-1:0] hcap_q;      // captured high time
  logic stb_q;                       // capture strobe
  wire rise = pin_i & ~prev_q;
  wire cnt_sat = (cnt_q == MSC_CNT_MAX);

  // counters saturate so the first period after a stopped input reads as the slowest period
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      prev_q <= 1'b0;
      cnt_q <= MSC_CNT_ZERO;
      hi_q <= MSC_CNT_ZERO;
      per_q <= MSC_CNT_ZERO;
      hcap_q <= MSC_CNT_ZERO;
      stb_q <= 1'b0;
    end
    else if (enable_i)
    begin
      prev_q <= pin_i;
      stb_q <= rise;
      if (rise)
      begin
        per_q <= cnt_q;
        hcap_q <= hi_q;
        cnt_q <= 24'h000001;
        hi_q <= 24'h000001;
      end
      else if (!cnt_sat)
      begin
        cnt_q <= cnt_q + 24'h000001;
        hi_q <= hi_q + {23'h000000, pin_i};
      end
    end
  end

  assign meas.period = per_q;
  assign meas.high = hcap_q;
  assign meas.strobe = stb_q;
endmodule : msc_pin_timer

// ### design/msc_speed_fault.sv
module msc_speed_fault
#(
  parameter int CMD_W = 16,
  parameter int CUR_W = 12,
  parameter int DESYNC_CYC = 2000000,         // longest zero-crossing gap while driving
  parameter int ABSENT_CYC = 1000000          // how long current must stay low
)
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire msc_pkg::msc_src_t speed_source_select_i,
  input wire logic pwm_input_band_i,          // 0 low band, 1 high band
  input wire logic override_i,
  input wire logic [CMD_W-1:0] host_speed_i,
  input wire logic [CMD_W-1:0] analog_level_i, // sampled converter result
  input wire logic speed_pin_i,               // asynchronous pin
  input wire logic zero_cross_i,              // asynchronous comparator event level
  input wire logic [CUR_W-1:0] phase_current_i,
  input wire logic [CUR_W-1:0] per_cycle_current_level_i,
  input wire logic [CUR_W-1:0] absent_load_current_level_i,
  input wire logic [23:0] overspeed_limit_i,  // in zero-crossings per 2^24 cycles
  input wire logic pwm_cycle_start_i,         // one pulse per pwm cycle
  input wire logic fault_clear_i,             // host clear pulse
  output logic [CMD_W-1:0] speed_command_o,
  output logic commutate_o,
  output logic drive_enable_o,
  output logic [23:0] zc_period_o,
  output logic overspeed_fault_o,
  output logic desync_fault_o,
  output logic absent_load_fault_o,
  output logic per_cycle_current_fault_o
);
  import msc_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] pin_sync_q;       // speed pin, stage 0 read by stage 1 only
  logic [1:0] zc_sync_q;        // zero-cross level
  logic zc_prev_q;              // for edge detect on the second stage
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      pin_sync_q <= 2'h0;
      zc_sync_q <= 2'h0;
      zc_prev_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      pin_sync_q <= {pin_sync_q[0], speed_pin_i};
      zc_sync_q <= {zc_sync_q[0], zero_cross_i};
      zc_prev_q <= zc_sync_q[1];
    end
  end
  wire zc_event = zc_sync_q[1] & ~zc_prev_q;

  // ----------------------------------------------------------------
  // speed pin timing
  // ----------------------------------------------------------------
  msc_meas_if meas ();
  msc_pin_timer u_timer
  (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .enable_i(clk_en_i),
    .pin_i(pin_sync_q[1]),
    .meas(meas)
  );

  // ----------------------------------------------------------------
  // command decode per source
  // ----------------------------------------------------------------
  // duty: high time over period, approximated by band shift to save a divider
  wire [39:0] duty_lo = {16'h0000, meas.high} << (CMD_W - MSC_BAND_LO_SH);
  wire [39:0] duty_hi = {16'h0000, meas.high} << (CMD_W - MSC_BAND_HI_SH);
  wire [39:0] duty_sel = pwm_input_band_i ? duty_hi : duty_lo;
  wire duty_over = (duty_sel[39:CMD_W] != 24'h000000);
  wire [CMD_W-1:0] duty_cmd = duty_over ? MSC_CMD_FULL : duty_sel[CMD_W-1:0];
  // frequency: full when period at or below the full-scale period
  localparam logic [23:0] FULL_PER = 24'(MSC_FULL_FREQ_CYC);
  localparam logic [39:0] FREQ_NUM = 40'(MSC_FULL_FREQ_CYC) * 40'h000000ffff;
  wire per_zero = (meas.period == MSC_CNT_ZERO);
  wire [39:0] freq_q40 = per_zero ? 40'h0 : FREQ_NUM / {16'h0000, meas.period};
  wire [CMD_W-1:0] freq_cmd = (!per_zero && meas.period <= FULL_PER) ? MSC_CMD_FULL
                                : freq_q40[CMD_W-1:0];
  logic [CMD_W-1:0] duty_q;     // latched duty command
  logic [CMD_W-1:0] freq_q;     // latched frequency command
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      duty_q <= MSC_CMD_ZERO;
      freq_q <= MSC_CMD_ZERO;
    end
    else if (clk_en_i && meas.strobe)
    begin
      duty_q <= duty_cmd;
      freq_q <= freq_cmd;
    end
  end

  // ----------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------
  logic [CMD_W-1:0] pin_cmd;
  always_comb
  begin
    case (speed_source_select_i)
      MSC_SRC_ANALOG: pin_cmd = analog_level_i;
      MSC_SRC_DUTY: pin_cmd = duty_q;
      MSC_SRC_FREQ: pin_cmd = freq_q;
      MSC_SRC_HOST: pin_cmd = host_speed_i;
      default: pin_cmd = MSC_CMD_ZERO;
    endcase
  end
  wire [CMD_W-1:0] cmd_d = override_i ? host_speed_i : pin_cmd;
  logic [CMD_W-1:0] cmd_q;
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      cmd_q <= MSC_CMD_ZERO;
    else if (clk_en_i)
      cmd_q <= cmd_d;
  end
  assign speed_command_o = cmd_q;
  assign commutate_o = (cmd_q != MSC_CMD_ZERO);

  // ----------------------------------------------------------------
  // zero-crossing interval and speed faults
  // ----------------------------------------------------------------
  logic [23:0] gap_q;           // cycles since the last crossing
  logic [23:0] zc_per_q;        // last measured interval
  logic over_q, desync_q, absent_q, pcl_q;
  logic [31:0] low_cnt_q;       // cycles with current below absent level
  localparam logic [23:0] DESYNC_LIM = 24'(DESYNC_CYC);
  localparam logic [31:0] ABSENT_LIM = 32'(ABSENT_CYC);
  // speed exceeds limit when the interval is shorter than 2^24/limit
  wire [23:0] lim_per = (overspeed_limit_i == 24'h0) ? 24'h0
                        : 24'(25'h1000000 / {1'b0, overspeed_limit_i});
  wire over_evt = zc_event && (gap_q < lim_per) && commutate_o;
  wire desync_evt = commutate_o && (gap_q >= DESYNC_LIM);
  wire cur_low = phase_current_i < absent_load_current_level_i;
  wire absent_evt = commutate_o && (low_cnt_q >= ABSENT_LIM);
  wire pcl_hit = phase_current_i >= per_cycle_current_level_i;
  logic cut_q;                  // drive cut for the rest of this pwm cycle

  // interval timer restarts on each crossing and saturates when stalled
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      gap_q <= 24'h0;
      zc_per_q <= 24'h0;
      low_cnt_q <= 32'h0;
      cut_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (zc_event)
      begin
        zc_per_q <= gap_q;
        gap_q <= 24'h000001;
      end
      else if (gap_q != MSC_CNT_MAX)
        gap_q <= gap_q + 24'h000001;
      low_cnt_q <= (cur_low && commutate_o && low_cnt_q != 32'hffffffff)
                   ? low_cnt_q + 32'h1 : (cur_low ? low_cnt_q : 32'h0);
      // new pwm cycle releases the cut, a hit within it cuts again
      if (pwm_cycle_start_i)
        cut_q <= 1'b0;
      else if (pcl_hit)
        cut_q <= 1'b1;
    end
  end
  assign drive_enable_o = commutate_o && !cut_q && !pcl_hit;
  assign zc_period_o = zc_per_q;

  // sticky flags: a new event wins over the host clear
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      over_q <= 1'b0;
      desync_q <= 1'b0;
      absent_q <= 1'b0;
      pcl_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      over_q <= over_evt | (over_q & ~fault_clear_i);
      desync_q <= desync_evt | (desync_q & ~fault_clear_i);
      absent_q <= absent_evt | (absent_q & ~fault_clear_i);
      pcl_q <= (pcl_hit & commutate_o) | (pcl_q & ~fault_clear_i);
    end
  end
  assign overspeed_fault_o = over_q;
  assign desync_fault_o = desync_q;
  assign absent_load_fault_o = absent_q;
  assign per_cycle_current_fault_o = pcl_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_clear_no_evt;
    clk_en_i && fault_clear_i && !pcl_hit;
  endsequence
  a_override_host: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && override_i |=> cmd_q == $past(host_speed_i))
    else $error("override did not take host value");
  a_source_analog: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && !override_i && speed_source_select_i == MSC_SRC_ANALOG
    |=> cmd_q == $past(analog_level_i))
    else $error("analog source not selected");
  a_source_duty: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && !override_i && speed_source_select_i == MSC_SRC_DUTY
    |=> cmd_q == $past(duty_q))
    else $error("duty source not selected");
  // checks the registered path, so a stuck or mis-enabled command register shows up
  a_commutate_cmd: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i |=> commutate_o == ($past(cmd_d) != MSC_CMD_ZERO))
    else $error("commutation not tied to command");
  a_zc_period: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && zc_event |=> zc_per_q == $past(gap_q) && gap_q == 24'h000001)
    else $error("zero-cross interval not captured");
  a_overspeed_set: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && over_evt |=> over_q)
    else $error("overspeed flag not set");
  a_desync_set: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && desync_evt |=> desync_q)
    else $error("desync flag not set");
  a_absent_set: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && absent_evt |=> absent_q)
    else $error("absent-load flag not set");
  a_current_cut: assert property (@(posedge clk_i) disable iff (reset_i)
    pcl_hit |-> !drive_enable_o)
    else $error("drive not cut at current level");
  a_cut_holds: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && pcl_hit && !pwm_cycle_start_i ##1 !pwm_cycle_start_i[*2]
    |-> !drive_enable_o)
    else $error("cut released inside pwm cycle");
  a_flag_sticky: assert property (@(posedge clk_i) disable iff (reset_i)
    pcl_q && !fault_clear_i |=> pcl_q)
    else $error("flag dropped without clear");
  a_flag_clear: assert property (@(posedge clk_i) disable iff (reset_i)
    pcl_q ##0 s_clear_no_evt |=> !pcl_q)
    else $error("flag not cleared");
  a_freq_full: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && meas.strobe && !per_zero && meas.period <= FULL_PER
    |=> freq_q == MSC_CMD_FULL)
    else $error("full-scale frequency not full command");
endmodule : msc_speed_fault

// ### testbench/msc_pin_source.sv
// speed pin signal source and back-emf crossing generator
module msc_pin_source
(
  input wire logic clk_i,
  input wire logic [23:0] period_i,  // pin period in cycles, taken at each rising edge
  input wire logic [23:0] high_i,    // high cycles within that period
  input wire logic [23:0] zc_gap_i,  // cycles between crossings, 0 stops them
  output logic pin_o,
  output logic zc_o,
  output int edges_o                 // rising edges sent so far
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] per_q = 24'h0;  // period in force
  logic [23:0] hi_q = 24'h0;   // high time in force
  logic [23:0] cnt_q = 24'h0;  // place within the period
  logic [23:0] zcnt_q = 24'h0; // place within the crossing gap
  initial
  begin
    pin_o = 1'b0;
    zc_o = 1'b0;
    edges_o = 0;
  end
  // --------------------------------------------------------------
  // waveforms, moved just after the edge like any other driver
  // --------------------------------------------------------------
  // new period and high-time settings land only at a period boundary, so a measured period is never torn
  always @(posedge clk_i)
  begin
    #1;
    if (cnt_q + 24'h1 >= per_q)
    begin
      cnt_q = 24'h0;
      per_q = period_i;
      hi_q = high_i;
      edges_o++;
    end
    else
      cnt_q++;
    pin_o = (cnt_q < hi_q);
    if (zc_gap_i == 24'h0)
    begin
      zcnt_q = 24'h0;
      zc_o = 1'b0;  // a stalled rotor gives no crossings
    end
    else
    begin
      zcnt_q = (zcnt_q + 24'h1 >= zc_gap_i) ? 24'h0 : zcnt_q + 24'h1;
      zc_o = (zcnt_q < 24'h2);
    end
  end
endmodule : msc_pin_source

// ### testbench/msc_speed_fault_tb.sv
module msc_speed_fault_tb;
  import msc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic clk_en = 1'b1;                 // low freezes every register of the device
  msc_src_t sel = MSC_SRC_HOST;
  logic band = 1'b0;
  logic override = 1'b0;
  logic [15:0] host = 16'h0000;
  logic [15:0] analog = 16'h0000;
  logic [11:0] cur = 12'h100;          // between the two current levels
  logic [23:0] os_limit = 24'h000000;  // overspeed check off at first
  logic pwm_start = 1'b0;
  logic clr = 1'b0;
  logic [23:0] per = 24'h001000;
  logic [23:0] hi = 24'h000400;
  logic [23:0] gap = 24'h000064;
  logic pin, zc, commutate, drive_en, f_os, f_ds, f_ab, f_pc;
  logic [15:0] cmd;
  logic [23:0] zc_per;
  int edges;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_cyc = 0;
  // --------------------------------------------------------------
  // clock, device and signal source
  // --------------------------------------------------------------
  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end
  msc_speed_fault #(.DESYNC_CYC(300), .ABSENT_CYC(50)) msc_speed_fault_i (
    .clk_i(clk_i), .reset_i(reset_i), .clk_en_i(clk_en), .speed_source_select_i(sel),
    .pwm_input_band_i(band), .override_i(override), .host_speed_i(host),
    .analog_level_i(analog), .speed_pin_i(pin), .zero_cross_i(zc), .phase_current_i(cur),
    .per_cycle_current_level_i(12'h800), .absent_load_current_level_i(12'h010),
    .overspeed_limit_i(os_limit), .pwm_cycle_start_i(pwm_start), .fault_clear_i(clr),
    .speed_command_o(cmd), .commutate_o(commutate), .drive_enable_o(drive_en),
    .zc_period_o(zc_per), .overspeed_fault_o(f_os), .desync_fault_o(f_ds),
    .absent_load_fault_o(f_ab), .per_cycle_current_fault_o(f_pc));
  msc_pin_source msc_pin_source_i (.clk_i(clk_i), .period_i(per), .high_i(hi),
    .zc_gap_i(gap), .pin_o(pin), .zc_o(zc), .edges_o(edges));
  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc
  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk
  // waits for n rising edges of the pin plus the sync and timer latency
  task automatic wait_edges(input int n);
    int target;
    target = edges + n;
    while (edges < target) cyc(1);
    cyc(10);
  endtask : wait_edges
  task automatic summarize;
    $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // a hang counts as a failure; the whole run needs at most some 85000 cycles
  always @(posedge clk_i)
  begin
    n_cyc++;
    if (n_cyc == 100000)
    begin
      n_mismatch++;
      summarize();
    end
  end
  // --------------------------------------------------------------
  // tests
  // --------------------------------------------------------------
  initial
  begin
    cyc(16);
    reset_i = 1'b0;
    cyc(1);
    chk("command after reset", cmd, 24'h0);
    chk("flags after reset", {f_os, f_ds, f_ab, f_pc, commutate}, 24'h0);
    $display("test reset done");
    host = 16'h1234;
    analog = 16'habcd;
    cyc(1);
    chk("host command", cmd, 24'h1234);
    chk("commutate", commutate, 24'h1);
    sel = MSC_SRC_ANALOG;
    cyc(2);
    chk("analog command", cmd, 24'habcd);
    override = 1'b1;
    cyc(2);
    chk("override command", cmd, 24'h1234);
    override = 1'b0;
    clk_en = 1'b0;  // frozen: the command must keep the override value
    cyc(2);
    chk("frozen command", cmd, 24'h1234);
    clk_en = 1'b1;
    cyc(2);
    chk("thawed command", cmd, 24'habcd);
    $display("test sources done");
    cyc(500);
    chk("crossing interval", zc_per, 24'h64);
    os_limit = 24'h040000;  // 64-cycle interval bound, as 150% of top speed would give
    cyc(500);
    chk("no early fault", {f_os, f_ds}, 24'h0);
    gap = 24'h000028;
    cyc(200);
    chk("overspeed", f_os, 24'h1);
    gap = 24'h000064;
    cyc(300);
    chk("overspeed held", f_os, 24'h1);
    gap = 24'h000000;
    cyc(400);
    chk("desync", f_ds, 24'h1);
    gap = 24'h000064;
    cur = 12'h000;
    cyc(80);
    chk("absent load", f_ab, 24'h1);
    cur = 12'h100;
    cyc(1);
    chk("drive on", drive_en, 24'h1);
    cur = 12'h800;  // at the level, as amps times gain would set it
    #1;
    chk("drive cut", drive_en, 24'h0);
    cyc(1);
    cur = 12'h100;
    cyc(2);
    chk("cut held", {f_pc, drive_en}, 24'h2);
    pwm_start = 1'b1;
    cyc(1);
    pwm_start = 1'b0;
    cyc(2);
    chk("cut released", drive_en, 24'h1);
    $display("test faults done");
    sel = MSC_SRC_HOST;
    host = 16'h0000;  // zero speed before clearing
    cyc(2);
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    cyc(400);
    chk("flags cleared", {f_os, f_ds, f_ab, f_pc, commutate}, 24'h0);
    $display("test clear done");
    sel = MSC_SRC_DUTY;
    band = 1'b1;
    wait_edges(2);
    chk("duty high band", cmd, 24'h4000);
    band = 1'b0;
    wait_edges(1);
    chk("duty low band", cmd, 24'h0400);
    $display("test duty done");
    sel = MSC_SRC_FREQ;
    per = 24'd20000;
    hi = 24'd10000;
    wait_edges(2);
    chk("full frequency", cmd, 24'hffff);
    per = 24'd25000;
    hi = 24'd12500;
    wait_edges(2);
    chk("lower frequency", cmd, 24'hcccc);
    $display("test frequency done");
    summarize();
  end
endmodule : msc_speed_fault_tb
